// ==== inc/smbus_slave_defines.svh ====
// timing, address and strap constants for the smbus register client
`ifndef SMBUS_SLAVE_DEFINES_SVH
`define SMBUS_SLAVE_DEFINES_SVH

// system clock rate
`define SMB_CLK_HZ 10000000

// lowest serial clock rate the host keeps to
`define SMB_MIN_SCL_KHZ 10

// clock held low this long aborts a transaction
`define SMB_STUCK_LOW_MS 30
`define SMB_STUCK_LOW_CYC ((`SMB_STUCK_LOW_MS * `SMB_CLK_HZ) / 1000)

// both lines high this long resets the client
`define SMB_IDLE_HIGH_US 150
`define SMB_IDLE_HIGH_CYC ((`SMB_IDLE_HIGH_US * `SMB_CLK_HZ) / 1000000)

// counter widths for the two line watchdogs
`define SMB_STUCK_CNT_W 20
`define SMB_IDLE_CNT_W 11

// client addresses chosen by the address select strap
`define SMB_ADDR_PIN_LOW 7'h2f
`define SMB_ADDR_PIN_FLOAT 7'h3d
`define SMB_ADDR_PIN_HIGH 7'h2e

// general alert response address
`define SMB_ARA_ADDR 7'h0c

// cycles after reset release before the strap is captured
`define SMB_STRAP_WAIT 2'h3

// bit index of the last bit in a byte
`define SMB_LAST_BIT 3'h7

`endif

// ==== inc/smbus_slave_pkg.sv ====
// types shared by the smbus register client
package smbus_slave_pkg;

    typedef enum logic [2:0] {
        st_idle   = 3'b000,
        st_addr   = 3'b001,
        st_index  = 3'b010,
        st_wdata  = 3'b011,
        st_ack    = 3'b100,
        st_tx     = 3'b101,
        st_mack   = 3'b110,
        st_ignore = 3'b111
    } smb_state_t;

endpackage

// ==== inc/line_event_if.sv ====
// bus line events from the line watcher to the protocol engine
`timescale 1ns/1ps
`default_nettype none

interface line_event_if;
    logic scl_rise;
    logic scl_fall;
    logic sda;
    logic start;
    logic stop;
    logic bus_reset;

    modport watch (
        output scl_rise,
        output scl_fall,
        output sda,
        output start,
        output stop,
        output bus_reset
    );

    modport proto (
        input scl_rise,
        input scl_fall,
        input sda,
        input start,
        input stop,
        input bus_reset
    );
endinterface

`default_nettype wire

// ==== logic/smbus_line_watch.sv ====
// synchronises the bus lines, finds edges, start, stop and timeouts
`timescale 1ns/1ps
`default_nettype none
`include "smbus_slave_defines.svh"

module smbus_line_watch
    import smbus_slave_pkg::*;
#(
    parameter int STUCK_LOW_CYC = `SMB_STUCK_LOW_CYC
) (
    input wire logic clk_i,             // system clock
    input wire logic rst_b_i,           // async reset, active low
    input wire logic scl_i,             // serial clock pin level
    input wire logic sda_i,             // serial data pin level
    input wire logic timeout_disable_i, // suppresses the stuck-low timeout
    line_event_if.watch ev              // events to the protocol engine
);

    localparam int IDLE_HIGH_CYC = `SMB_IDLE_HIGH_CYC;

    logic [1:0] scl_meta_q;
    logic [1:0] sda_meta_q;
    logic scl_prev_q;
    logic sda_prev_q;
    logic [`SMB_STUCK_CNT_W-1:0] low_cnt_q;
    logic [`SMB_IDLE_CNT_W-1:0] idle_cnt_q;
    logic stuck_fire;
    logic idle_fire;

    ////////////////////////////////////////////////////////////////////////
    // two-flop synchronisers; index 0 is read only by index 1
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            scl_meta_q <= 2'h3;
            sda_meta_q <= 2'h3;
            scl_prev_q <= 1'b1;
            sda_prev_q <= 1'b1;
        end else begin
            scl_meta_q <= {scl_meta_q[0], scl_i};
            sda_meta_q <= {sda_meta_q[0], sda_i};
            scl_prev_q <= scl_meta_q[1];
            sda_prev_q <= sda_meta_q[1];
        end
    end

    assign ev.sda = sda_meta_q[1];
    // edges only; clock stretching by others just delays them
    assign ev.scl_rise = scl_meta_q[1] & ~scl_prev_q;
    assign ev.scl_fall = ~scl_meta_q[1] & scl_prev_q;
    // data moves while clock held high on both samples
    assign ev.start = scl_meta_q[1] & scl_prev_q & sda_prev_q & ~sda_meta_q[1];
    assign ev.stop = scl_meta_q[1] & scl_prev_q & ~sda_prev_q & sda_meta_q[1];

    ////////////////////////////////////////////////////////////////////////
    // clock held low watchdog, saturates so it fires once per hold
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            low_cnt_q <= '0;
        end else if (scl_meta_q[1]) begin
            low_cnt_q <= '0;
        end else if (low_cnt_q <= `SMB_STUCK_CNT_W'(STUCK_LOW_CYC)) begin
            low_cnt_q <= low_cnt_q + `SMB_STUCK_CNT_W'(1);
        end
    end

    assign stuck_fire = (low_cnt_q == `SMB_STUCK_CNT_W'(STUCK_LOW_CYC)) & ~scl_meta_q[1]
                        & ~timeout_disable_i;

    // both lines high watchdog
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            idle_cnt_q <= '0;
        end else if (!(scl_meta_q[1] & sda_meta_q[1])) begin
            idle_cnt_q <= '0;
        end else if (idle_cnt_q <= `SMB_IDLE_CNT_W'(IDLE_HIGH_CYC)) begin
            idle_cnt_q <= idle_cnt_q + `SMB_IDLE_CNT_W'(1);
        end
    end

    assign idle_fire = (idle_cnt_q == `SMB_IDLE_CNT_W'(IDLE_HIGH_CYC))
                       & scl_meta_q[1] & sda_meta_q[1];

    assign ev.bus_reset = stuck_fire | idle_fire;

endmodule

`default_nettype wire

// ==== logic/smbus_register_slave.sv ====
// smbus client engine: register pointer, byte transfers, alert response
`timescale 1ns/1ps
`default_nettype none
`include "smbus_slave_defines.svh"

module smbus_register_slave
    import smbus_slave_pkg::*;
#(
    parameter int STUCK_LOW_CYC = `SMB_STUCK_LOW_CYC
) (
    input wire logic clk_i,             // system clock, 10 MHz
    input wire logic rst_b_i,           // async reset, active low
    input wire logic scl_i,             // serial clock pin, input only
    input wire logic sda_i,             // serial data pin level
    output logic sda_o,                 // serial data drive value, always low
    output logic sda_oe_o,              // high while pulling data low
    input wire logic addr_sel_i,        // address strap level
    input wire logic addr_sel_float_i,  // address strap seen floating
    input wire logic timeout_disable_i, // suppresses the stuck-low timeout
    input wire logic alert_src_i,       // device event wanting attention
    input wire logic alert_mask_clr_i,  // clears the alert suppress bit
    output logic alert_o,               // alert output, active high
    output logic alert_mask_o,          // alert suppress bit
    output logic [6:0] own_addr_o,      // client address in use
    output logic [7:0] reg_addr_o,      // register pointer
    output logic [7:0] reg_wdata_o,     // byte to store
    output logic reg_wr_o,              // store pulse at reg_addr_o
    output logic reg_rd_o,              // read pulse, byte taken from reg_rdata_i
    input wire logic [7:0] reg_rdata_i  // register at reg_addr_o, same cycle
);

    line_event_if ev ();

    smb_state_t state_q;
    smb_state_t next_q;
    logic [2:0] bit_cnt_q;
    logic [7:0] shift_q;
    logic byte_rdy_q;
    logic [7:0] tx_q;
    logic oe_q;
    logic ara_q;
    logic host_ack_q;
    logic [7:0] ptr_q;
    logic [7:0] wdata_q;
    logic wr_q;
    logic rd_q;
    logic mask_q;
    logic alert_q;
    logic [1:0] sel_meta_q;
    logic [1:0] flt_meta_q;
    logic [1:0] strap_cnt_q;
    logic strap_done_q;
    logic [6:0] own_addr_q;

    logic rx_state;
    logic do_byte;
    logic addr_hit;
    logic ara_hit;
    logic index_load;
    logic wr_fire;
    logic load_tx;
    logic rd_fire;
    logic rd_advance;
    logic ara_done;
    logic [7:0] tx_src;

    ////////////////////////////////////////////////////////////////////////
    // line watcher
    smbus_line_watch #(
        .STUCK_LOW_CYC(STUCK_LOW_CYC)
    ) u_watch (
        .clk_i(clk_i),
        .rst_b_i(rst_b_i),
        .scl_i(scl_i),
        .sda_i(sda_i),
        .timeout_disable_i(timeout_disable_i),
        .ev(ev.watch)
    );

    ////////////////////////////////////////////////////////////////////////
    // address strap, caught once the synchronisers have settled
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            sel_meta_q <= 2'h0;
            flt_meta_q <= 2'h0;
        end else begin
            sel_meta_q <= {sel_meta_q[0], addr_sel_i};
            flt_meta_q <= {flt_meta_q[0], addr_sel_float_i};
        end
    end

    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            strap_cnt_q <= 2'h0;
            strap_done_q <= 1'b0;
            own_addr_q <= `SMB_ADDR_PIN_FLOAT;
        end else if (!strap_done_q) begin
            strap_cnt_q <= strap_cnt_q + 2'h1;
            if (strap_cnt_q == `SMB_STRAP_WAIT) begin
                strap_done_q <= 1'b1;
                if (flt_meta_q[1]) begin
                    own_addr_q <= `SMB_ADDR_PIN_FLOAT;
                end else if (sel_meta_q[1]) begin
                    own_addr_q <= `SMB_ADDR_PIN_HIGH;
                end else begin
                    own_addr_q <= `SMB_ADDR_PIN_LOW;
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // decode of the byte just received and of the transmit hand-offs
    always_comb begin
        rx_state = (state_q == st_addr) | (state_q == st_index) | (state_q == st_wdata);
        do_byte = ev.scl_fall & byte_rdy_q & rx_state;
        addr_hit = (shift_q[7:1] == own_addr_q);
        // the alert address is only answered while the alert is raised
        ara_hit = (shift_q[7:1] == `SMB_ARA_ADDR) & shift_q[0] & alert_q;
        index_load = do_byte & (state_q == st_index);
        wr_fire = do_byte & (state_q == st_wdata);
        load_tx = ev.scl_fall & (((state_q == st_ack) & (next_q == st_tx))
                  | ((state_q == st_mack) & host_ack_q & ~ara_q));
        rd_fire = load_tx & ~ara_q;
        rd_advance = ev.scl_rise & (state_q == st_mack) & ~ev.sda & ~ara_q;
        ara_done = ev.scl_rise & (state_q == st_mack) & ara_q;
        tx_src = ara_q ? {own_addr_q, 1'b0} : reg_rdata_i;
    end

    ////////////////////////////////////////////////////////////////////////
    // protocol engine; stop, timeout and start override any state
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            state_q <= st_idle;
            next_q <= st_idle;
            bit_cnt_q <= 3'h0;
            shift_q <= 8'h00;
            byte_rdy_q <= 1'b0;
            tx_q <= 8'h00;
            oe_q <= 1'b0;
            ara_q <= 1'b0;
            host_ack_q <= 1'b0;
        end else if (ev.bus_reset | ev.stop) begin
            state_q <= st_idle;
            oe_q <= 1'b0;
            byte_rdy_q <= 1'b0;
            ara_q <= 1'b0;
        end else if (ev.start) begin
            // a repeated start lands here too, keeping the pointer
            state_q <= st_addr;
            bit_cnt_q <= 3'h0;
            byte_rdy_q <= 1'b0;
            oe_q <= 1'b0;
            ara_q <= 1'b0;
        end else begin
            unique case (state_q)
                st_idle, st_ignore: begin
                    oe_q <= 1'b0;
                end
                st_addr, st_index, st_wdata: begin
                    if (ev.scl_rise) begin
                        shift_q <= {shift_q[6:0], ev.sda};
                        bit_cnt_q <= bit_cnt_q + 3'h1;
                        byte_rdy_q <= (bit_cnt_q == `SMB_LAST_BIT);
                    end else if (do_byte) begin
                        byte_rdy_q <= 1'b0;
                        bit_cnt_q <= 3'h0;
                        if (state_q != st_addr) begin
                            // index and every data byte are acked; no count byte
                            oe_q <= 1'b1;
                            state_q <= st_ack;
                            next_q <= st_wdata;
                        end else if (addr_hit) begin
                            oe_q <= 1'b1;
                            state_q <= st_ack;
                            next_q <= shift_q[0] ? st_tx : st_index;
                        end else if (ara_hit) begin
                            oe_q <= 1'b1;
                            state_q <= st_ack;
                            next_q <= st_tx;
                            ara_q <= 1'b1;
                        end else begin
                            state_q <= st_ignore;
                        end
                    end
                end
                st_ack: begin
                    if (ev.scl_fall) begin
                        bit_cnt_q <= 3'h0;
                        if (next_q == st_tx) begin
                            tx_q <= tx_src;
                            oe_q <= ~tx_src[7];
                            state_q <= st_tx;
                        end else begin
                            oe_q <= 1'b0;
                            state_q <= next_q;
                        end
                    end
                end
                st_tx: begin
                    if (ev.scl_rise & ~oe_q & ~ev.sda) begin
                        // a released one read back low: contention lost
                        oe_q <= 1'b0;
                        state_q <= st_ignore;
                    end else if (ev.scl_fall) begin
                        if (bit_cnt_q == `SMB_LAST_BIT) begin
                            oe_q <= 1'b0;
                            state_q <= st_mack;
                        end else begin
                            bit_cnt_q <= bit_cnt_q + 3'h1;
                            tx_q <= {tx_q[6:0], 1'b0};
                            oe_q <= ~tx_q[6];
                        end
                    end
                end
                st_mack: begin
                    if (ev.scl_rise) begin
                        host_ack_q <= ~ev.sda;
                    end else if (ev.scl_fall) begin
                        bit_cnt_q <= 3'h0;
                        if (host_ack_q & ~ara_q) begin
                            tx_q <= reg_rdata_i;
                            oe_q <= ~reg_rdata_i[7];
                            state_q <= st_tx;
                        end else begin
                            // nack ends the read; wait for the stop
                            state_q <= st_ignore;
                        end
                    end
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // register pointer: survives stop, moves only on index, after each store, or on each host-acked read byte
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            ptr_q <= 8'h00;
        end else if (index_load) begin
            ptr_q <= shift_q;
        end else if (wr_q | rd_advance) begin
            // advance after the store so reg_addr_o is stable during it
            ptr_q <= ptr_q + 8'h01;
        end
    end

    // store and fetch strobes toward the register file
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            wr_q <= 1'b0;
            wdata_q <= 8'h00;
            rd_q <= 1'b0;
        end else begin
            wr_q <= wr_fire;
            rd_q <= rd_fire;
            if (wr_fire) begin
                wdata_q <= shift_q;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // alert suppress; a clean reply wins over a same-cycle clear
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            mask_q <= 1'b0;
        end else if (ara_done) begin
            mask_q <= 1'b1;
        end else if (alert_mask_clr_i) begin
            mask_q <= 1'b0;
        end
    end

    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            alert_q <= 1'b0;
        end else begin
            alert_q <= alert_src_i & ~mask_q & ~ara_done;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // outputs; no clock drive exists at all, so no stretching
    assign sda_o = 1'b0;
    assign sda_oe_o = oe_q;
    assign alert_o = alert_q;
    assign alert_mask_o = mask_q;
    assign own_addr_o = own_addr_q;
    assign reg_addr_o = ptr_q;
    assign reg_wdata_o = wdata_q;
    assign reg_wr_o = wr_q;
    assign reg_rd_o = rd_q;

endmodule

`default_nettype wire

// ==== sim/smbus_host_model.sv ====
// host controller model driving the two-wire link from outside the device
`timescale 1ns/1ps
`default_nettype none

module smbus_host_model #(
    parameter int Q = 200 // quarter bit in ns, far above the slowest allowed rate
) (
    output logic scl_o, // clock line level
    output logic sda_dn_o, // high while the host pulls data low
    input wire logic sda_i // resolved data line, pulled up
);
    initial begin
        scl_o = 1'b1;
        sda_dn_o = 1'b0;
    end

    ////////////////////////////////////////////////////////////////////////////
    // one bit, entered and left with the clock low
    task automatic bit_x(input logic v, output logic s);
        #(Q) sda_dn_o = ~v;
        #(Q) scl_o = 1'b1;
        #(Q) s = sda_i;
        #(Q) scl_o = 1'b0;
    endtask

    // also serves as repeated start from a low clock
    task automatic start();
        #(Q) sda_dn_o = 1'b0;
        #(Q) scl_o = 1'b1;
        #(Q) sda_dn_o = 1'b1;
        #(Q) scl_o = 1'b0;
    endtask

    task automatic stop();
        #(Q) sda_dn_o = 1'b1;
        #(Q) scl_o = 1'b1;
        #(Q) sda_dn_o = 1'b0;
        #(4 * Q);
    endtask

    task automatic put_byte(input logic [7:0] b, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--) bit_x(b[i], s);
        bit_x(1'b1, s);
        ack = ~s;
    endtask

    // jam bits are pulled low by the host to lose the device a bit on purpose
    task automatic get_byte(input logic nack, input logic [7:0] jam, output logic [7:0] b);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            bit_x(~jam[i], s);
            b[i] = s;
        end
        bit_x(nack, s);
    endtask

    // both lines left high for n system clocks, then clock low again
    task automatic park_high(input int n);
        #(Q) sda_dn_o = 1'b0;
        #(Q) scl_o = 1'b1;
        #(n * 100) scl_o = 1'b0;
    endtask
endmodule

`default_nettype wire

// ==== sim/smbus_register_slave_chk.sv ====
// concurrent checks on the smbus client's ports
`timescale 1ns/1ps
`default_nettype none

module smbus_register_slave_chk #(
    parameter int STUCK_LOW_CYC = 300000
) (
    input wire logic clk_i, // system clock
    input wire logic rst_b_i, // async reset, active low
    input wire logic scl_i, // serial clock pin
    input wire logic sda_o, // data drive value
    input wire logic sda_oe_o, // data pull enable
    input wire logic addr_sel_i, // strap level
    input wire logic addr_sel_float_i, // strap floating
    input wire logic timeout_disable_i, // stuck-low timeout off
    input wire logic alert_src_i, // alert cause
    input wire logic alert_mask_clr_i, // suppress clear
    input wire logic alert_o, // alert output
    input wire logic alert_mask_o, // suppress bit
    input wire logic [6:0] own_addr_o, // client address
    input wire logic [7:0] reg_addr_o, // register pointer
    input wire logic reg_wr_o, // store pulse
    input wire logic reg_rd_o // read pulse
);
    logic [2:0] up_q;
    logic [19:0] low_q;
    logic [6:0] strap_w;

    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            up_q <= 3'h0;
        end else if (up_q != 3'h7) begin
            up_q <= up_q + 3'h1;
        end
    end

    // run of clock-low cycles, only while the timeout is armed
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            low_q <= 20'h0_0000;
        end else if (scl_i || timeout_disable_i) begin
            low_q <= 20'h0_0000;
        end else if (low_q != 20'hf_ffff) begin
            low_q <= low_q + 20'h0_0001;
        end
    end

    assign strap_w = addr_sel_float_i ? 7'h3d : (addr_sel_i ? 7'h2e : 7'h2f);

    default clocking dc @(posedge clk_i); endclocking
    default disable iff (!rst_b_i);

    ////////////////////////////////////////////////////////////////////////////
    open_drain_a: assert property (sda_o == 1'b0)
        else $error("data drive value not low");
    low_change_a: assert property ($changed(sda_oe_o) |-> !scl_i)
        else $error("data drive changed while clock high");
    store_ack_a: assert property (reg_wr_o |-> sda_oe_o && !scl_i)
        else $error("store outside an acknowledge");
    store_step_a: assert property (reg_wr_o |=> !reg_wr_o && reg_addr_o == $past(reg_addr_o) + 8'h01)
        else $error("pointer not advanced after store");
    take_rd_a: assert property (reg_rd_o |-> !scl_i ##1 !reg_rd_o)
        else $error("read pulse misplaced");
    alert_on_a: assert property (alert_src_i && !alert_mask_o |=> alert_o ^ alert_mask_o)
        else $error("alert missing");
    alert_off_a: assert property (!alert_src_i || alert_mask_o |=> !alert_o)
        else $error("alert not withdrawn");
    mask_set_a: assert property ($rose(alert_mask_o) |-> scl_i && $past(alert_o))
        else $error("suppress set without alert reply");
    mask_clr_a: assert property ($fell(alert_mask_o) |-> $past(alert_mask_clr_i))
        else $error("suppress cleared without request");
    stuck_idle_a: assert property (int'(low_q) > STUCK_LOW_CYC + 8 |-> !sda_oe_o)
        else $error("data held after clock stuck low");
    strap_addr_a: assert property (up_q == 3'h7 |-> own_addr_o == strap_w)
        else $error("client address does not follow strap");

    cover property ($rose(alert_mask_o));
    cover property (reg_wr_o);
    cover property (reg_rd_o);
    cover property (int'(low_q) > STUCK_LOW_CYC + 8);
endmodule

bind smbus_register_slave smbus_register_slave_chk #(
    .STUCK_LOW_CYC(STUCK_LOW_CYC)
) chk_u (
    .clk_i, .rst_b_i, .scl_i, .sda_o, .sda_oe_o, .addr_sel_i, .addr_sel_float_i,
    .timeout_disable_i, .alert_src_i, .alert_mask_clr_i, .alert_o, .alert_mask_o,
    .own_addr_o, .reg_addr_o, .reg_wr_o, .reg_rd_o
);

`default_nettype wire

// ==== sim/test_smbus_register_slave.sv ====
// self-checking bench for the smbus register client
`timescale 1ns/1ps
`default_nettype none

module test_smbus_register_slave;
    localparam int STUCK = 200;
    logic clk_i, rst_b_i, scl_i, sda_i, sda_o, sda_oe_o, dn, ack;
    logic addr_sel_i, addr_sel_float_i, timeout_disable_i;
    logic alert_src_i, alert_mask_clr_i, alert_o, alert_mask_o;
    logic reg_wr_o, reg_rd_o;
    logic [6:0] own_addr_o, own;
    logic [7:0] reg_addr_o, reg_wdata_o, reg_rdata_i, ptr, b;
    logic [7:0] mem [256];
    logic [7:0] exp [256];
    logic [15:0] rows [6] = '{16'h005a, 16'h01a5, 16'h7f80, 16'h807f, 16'hfeff, 16'hff00};
    int bad_count, check_count, cyc, wr_seen, wc;

    assign sda_i = ~(dn | sda_oe_o);
    assign reg_rdata_i = mem[reg_addr_o];

    smbus_register_slave #(.STUCK_LOW_CYC(STUCK)) dut_u (
        .clk_i, .rst_b_i, .scl_i, .sda_i, .sda_o, .sda_oe_o, .addr_sel_i, .addr_sel_float_i,
        .timeout_disable_i, .alert_src_i, .alert_mask_clr_i, .alert_o, .alert_mask_o,
        .own_addr_o, .reg_addr_o, .reg_wdata_o, .reg_wr_o, .reg_rd_o, .reg_rdata_i
    );
    smbus_host_model host_u (.scl_o(scl_i), .sda_dn_o(dn), .sda_i(sda_i));

    initial begin
        clk_i = 1'b0;
        forever #50 clk_i = ~clk_i;
    end

    always @(posedge clk_i) begin
        if (reg_wr_o) begin
            mem[reg_addr_o] <= reg_wdata_o;
            wr_seen++;
        end
        cyc++;
        if (cyc == 40000) begin
            bad_count++;
            summarize();
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    task automatic summarize();
        if (bad_count == 0 && check_count > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] want);
        check_count++;
        if (seen !== want) begin
            bad_count++;
            $display("BAD t=%0t seen=%h want=%h", $time, seen, want);
        end
    endtask

    // keeps link activity off the system clock edges
    task automatic step(input int n);
        repeat (n) @(posedge clk_i);
        #13;
    endtask

    task automatic do_reset(input logic f, input logic s, input logic [6:0] a);
        @(posedge clk_i);
        rst_b_i <= 1'b0;
        addr_sel_float_i <= f;
        addr_sel_i <= s;
        step(16);
        check({sda_oe_o, alert_o, alert_mask_o, reg_wr_o, reg_rd_o, own_addr_o, reg_addr_o,
            reg_wdata_o}, 28'h03d_0000);
        @(posedge clk_i);
        rst_b_i <= 1'b1;
        step(12);
        check(own_addr_o, a);
        own = a;
    endtask

    task automatic wr(input logic [7:0] idx, input int n, input logic [7:0] d);
        host_u.start();
        host_u.put_byte({own, 1'b0}, ack);
        check(ack, 1);
        host_u.put_byte(idx, ack);
        check(ack, 1);
        for (int i = 0; i < n; i++) begin
            host_u.put_byte(d + 8'(i), ack);
            check(ack, 1);
            exp[idx + 8'(i)] = d + 8'(i);
        end
        host_u.stop();
        ptr = idx + 8'(n);
        check(reg_addr_o, ptr);
    endtask

    // no count byte: plain layout, host nacks only the last byte
    task automatic rd(input logic with_idx, input logic [7:0] idx, input int n);
        if (with_idx) begin
            host_u.start();
            host_u.put_byte({own, 1'b0}, ack);
            check(ack, 1);
            host_u.put_byte(idx, ack);
            check(ack, 1);
            ptr = idx;
        end
        host_u.start();
        host_u.put_byte({own, 1'b1}, ack);
        check(ack, 1);
        for (int i = 0; i < n; i++) begin
            host_u.get_byte(i == n - 1, 8'h00, b);
            check(b, exp[ptr + 8'(i)]);
        end
        host_u.stop();
        ptr = ptr + 8'(n - 1);
        check(reg_addr_o, ptr);
    endtask

    ////////////////////////////////////////////////////////////////////////////
    initial begin
        rst_b_i = 1'b0;
        addr_sel_i = 1'b0;
        addr_sel_float_i = 1'b0;
        timeout_disable_i = 1'b0;
        alert_src_i = 1'b0;
        alert_mask_clr_i = 1'b0;
        for (int i = 0; i < 256; i++) begin
            mem[i] = 8'(i) ^ 8'h3c;
            exp[i] = mem[i];
        end
        do_reset(1'b1, 1'b0, 7'h3d);
        do_reset(1'b0, 1'b1, 7'h2e);
        do_reset(1'b0, 1'b0, 7'h2f);
        foreach (rows[k]) begin
            wr(rows[k][15:8], 1, rows[k][7:0]);
            rd(1'b1, rows[k][15:8], 1);
        end
        wc = wr_seen;
        wr(8'h21, 0, 8'h00);
        check(wr_seen, wc);
        rd(1'b0, 8'h00, 1);
        rd(1'b0, 8'h00, 1);
        wr(8'h40, 4, 8'hc1);
        rd(1'b1, 8'h40, 4);
        host_u.start();
        host_u.put_byte(8'hb2, ack);
        check(ack, 0);
        host_u.stop();
        @(posedge clk_i);
        alert_src_i <= 1'b1;
        step(4);
        check(alert_o, 1);
        for (int t = 0; t < 2; t++) begin
            host_u.start();
            host_u.put_byte(8'h19, ack);
            check(ack, 1);
            host_u.get_byte(1'b1, t ? 8'h00 : 8'h40, b);
            host_u.stop();
            check(alert_mask_o, t[0]);
        end
        check(b, {own, 1'b0});
        check(alert_o, 0);
        @(posedge clk_i);
        alert_mask_clr_i <= 1'b1;
        @(posedge clk_i);
        alert_mask_clr_i <= 1'b0;
        alert_src_i <= 1'b0;
        step(3);
        check({alert_mask_o, alert_o}, 2'b00);
        host_u.start();
        host_u.put_byte(8'h19, ack);
        check(ack, 0);
        host_u.stop();
        // clock held low while the device is sending a zero bit
        for (int t = 0; t < 2; t++) begin
            @(posedge clk_i);
            timeout_disable_i <= t[0];
            step(2);
            wr(8'h10, 0, 8'h00);
            host_u.start();
            host_u.put_byte({own, 1'b1}, ack);
            #(STUCK * 100 + 3000);
            check(sda_oe_o, t[0]);
            if (t == 1) begin
                host_u.get_byte(1'b1, 8'h00, b);
                check(b, exp[8'h10]);
            end
            host_u.stop();
        end
        host_u.start();
        host_u.put_byte({own, 1'b0}, ack);
        host_u.park_high(1700);
        host_u.put_byte(8'h22, ack);
        host_u.stop();
        check(reg_addr_o, ptr);
        summarize();
    end
endmodule

`default_nettype wire
